// ---- core/mbsp_pkg.sv ----
// package of the serial port block: map, reset values, types
// assumes a 100 MHz module clock and a 32-bit apb register bus
package mbsp_pkg;

  // ----------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------
  localparam int NPORT = 2;
  localparam int CLK_NS = 10;
  localparam int CLK_HZ = 1_000_000_000 / CLK_NS;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int RATE_UNIT_BPS = 100;
  localparam int OVERSAMPLE = 16;
  localparam logic [20:0] NCO_LIMIT = 21'(CLK_HZ / RATE_UNIT_BPS);
  // rtu end of frame: 3.5 chars of 11 bits, in 16x ticks
  localparam logic [9:0] RTU_GAP = 10'(7 * 11 * OVERSAMPLE / 2);

  // ----------------------------------------------------------
  // register map, byte offsets inside one port window
  // ----------------------------------------------------------
  localparam int PORT_BIT = 5;
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_RATE = 5'h04;
  localparam logic [4:0] OFS_DLY = 5'h08;
  localparam logic [4:0] OFS_TMO = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_MASK = 5'h14;
  localparam logic [4:0] OFS_DATA = 5'h18;
  localparam logic [4:0] OFS_STATE = 5'h1c;

  // ----------------------------------------------------------
  // fields, limits and reset values
  // ----------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;

  typedef struct packed {
    logic master;
    logic rtu;
    logic stop2;
    logic [1:0] par;
    logic data8;
    logic custom;
    logic [2:0] baud;
    logic pwr_on;
    logic [7:0] station;
  } mbsp_cfg_type;

  typedef struct packed {
    logic stop2;
    logic [1:0] par;
    logic data8;
  } mbsp_fmt_type;

  localparam mbsp_cfg_type CFG_RST = 19'h08601;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hfe;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [12:0] RATE_RST = 13'h0060;
  localparam logic [12:0] RATE_MIN = 13'h0001;
  localparam logic [12:0] RATE_MAX = 13'h1388;
  localparam logic [11:0] DLY_RST = 12'h000;
  localparam logic [11:0] TMO_RST = 12'h0c8;
  localparam logic [11:0] MS_MAX = 12'hbb8;
  // standard rates in 100 bps units, index 3 is 9600
  localparam logic [12:0] STD_RATE [8] = '{13'h000c, 13'h0018,
    13'h0030, 13'h0060, 13'h00c0, 13'h0180, 13'h0240, 13'h0480};
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_LF = 8'h0a;

  // ----------------------------------------------------------
  // event bits of the status and mask registers
  // ----------------------------------------------------------
  localparam int NEV = 7;
  localparam int EV_RXCHAR = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_BCAST = 2;
  localparam int EV_ERR = 3;
  localparam int EV_REPLY = 4;
  localparam int EV_TMO = 5;
  localparam int EV_TXDONE = 6;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10
  } mbsp_rx_type;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } mbsp_tx_type;

  typedef enum logic [1:0] {
    REP_IDLE = 2'b00,
    REP_WAIT = 2'b01,
    REP_OPEN = 2'b10
  } mbsp_rep_type;

endpackage

// ---- core/mbsp_uart.sv ----
// character transmitter and receiver of one serial port
// assumes a 16x bit rate tick and rxd synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
module mbsp_uart import mbsp_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // rate and format
  input wire logic tick_i,
  input wire mbsp_fmt_type fmt_i,
  // transmit side
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  output logic tx_done_o,
  output logic txd_o,
  // receive side
  input wire logic rxd_i,
  output logic rx_valid_o,
  output logic rx_err_o,
  output logic [7:0] rx_data_o
);

  mbsp_tx_type tx_st, next_tx_st;
  mbsp_rx_type rx_st, next_rx_st;
  logic [11:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [3:0] tx_left, next_tx_left, tx_cnt, next_tx_cnt;
  logic [3:0] rx_cnt, next_rx_cnt, rx_idx, next_rx_idx;
  logic [3:0] nb, ppos;
  logic next_done, next_rxv, next_rxe;
  logic [7:0] next_rxd, dat;
  logic par;

  // frame length and parity position from the format
  always_comb begin
    ppos = fmt_i.data8 ? 4'h9 : 4'h8;
    nb = 4'h9 + {3'h0, fmt_i.data8} + {3'h0, fmt_i.par != PAR_NONE}
      + {3'h0, fmt_i.stop2};
  end

  assign tx_ready_o = (tx_st == TX_IDLE);
  assign txd_o = tx_sh[0];

  // transmit shifter
  always_comb begin
    next_tx_st = tx_st;
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_cnt = tx_cnt;
    next_done = 1'b0;
    dat = fmt_i.data8 ? tx_data_i : {1'b0, tx_data_i[6:0]};
    par = (^dat) ^ (fmt_i.par == PAR_ODD);
    case (tx_st)
      TX_IDLE: begin
        if (tx_valid_i) begin
          next_tx_sh = 12'hfff;
          next_tx_sh[8:1] = dat;
          if (!fmt_i.data8) begin
            next_tx_sh[8] = 1'b1;
          end
          if (fmt_i.par != PAR_NONE) begin
            next_tx_sh[ppos] = par;
          end
          next_tx_sh[0] = 1'b0;
          next_tx_left = nb;
          next_tx_cnt = 4'h0;
          next_tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tick_i) begin
          next_tx_cnt = tx_cnt + 4'h1;
          if (tx_cnt == 4'hf) begin
            next_tx_sh = {1'b1, tx_sh[11:1]};
            next_tx_left = tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              next_tx_st = TX_IDLE;
              next_done = 1'b1;
            end
          end
        end
      end
      default: next_tx_st = TX_IDLE;
    endcase
  end

  // receive sampler, mid-bit on the 16x tick
  always_comb begin
    next_rx_st = rx_st;
    next_rx_sh = rx_sh;
    next_rx_cnt = rx_cnt;
    next_rx_idx = rx_idx;
    next_rxv = 1'b0;
    next_rxe = rx_err_o;
    next_rxd = rx_data_o;
    case (rx_st)
      RX_IDLE: begin
        if (tick_i && !rxd_i) begin
          next_rx_cnt = 4'h0;
          next_rx_st = RX_START;
        end
      end
      RX_START: begin
        if (tick_i) begin
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == 4'h7) begin
            next_rx_cnt = 4'h0;
            next_rx_idx = 4'h1;
            next_rx_st = rxd_i ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick_i) begin
          next_rx_cnt = rx_cnt + 4'h1;
          if (rx_cnt == 4'hf) begin
            next_rx_sh[rx_idx] = rxd_i;
            next_rx_idx = rx_idx + 4'h1;
            if (rx_idx == nb - 4'h1) begin
              next_rx_st = RX_IDLE;
              next_rxv = 1'b1;
              next_rxd = fmt_i.data8 ? next_rx_sh[8:1]
                : {1'b0, next_rx_sh[7:1]};
              next_rxe = !next_rx_sh[nb - 4'h1];
              if (fmt_i.par != PAR_NONE) begin
                next_rxe = next_rxe | ((^next_rxd)
                  ^ (fmt_i.par == PAR_ODD) ^ next_rx_sh[ppos]);
              end
            end
          end
        end
      end
      default: next_rx_st = RX_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_st <= TX_IDLE;
      tx_sh <= 12'hfff;
      tx_left <= 4'h0;
      tx_cnt <= 4'h0;
      tx_done_o <= 1'b0;
      rx_st <= RX_IDLE;
      rx_sh <= 12'h000;
      rx_cnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_valid_o <= 1'b0;
      rx_err_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      tx_st <= next_tx_st;
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_cnt <= next_tx_cnt;
      tx_done_o <= next_done;
      rx_st <= next_rx_st;
      rx_sh <= next_rx_sh;
      rx_cnt <= next_rx_cnt;
      rx_idx <= next_rx_idx;
      rx_valid_o <= next_rxv;
      rx_err_o <= next_rxe;
      rx_data_o <= next_rxd;
    end
  end

endmodule
`default_nettype wire

// ---- core/mbsp_top.sv ----
// two modbus serial ports with apb registers and one interrupt
// assumes apb master on mclk_i; rxd, run inputs synchronous
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) station address 1..254 per port picks frames meant for us
// (R2) other devices keep slave addresses nonzero and unique
// (R3) frames to station zero are broadcasts to every slave
// (R4) slave accepts station zero frames whatever its own address
// (R5) stop-to-run mode: port works only after stop to run change
// (R6) power-on mode: port works at once, regardless of run state
// (R7) bit rate from standard list, default 9600, or custom 1..5000
// (R8) reply waits a delay of 0..3000 ms, default 0
// (R9) master gives up waiting for data after 0..3000 ms, default 200
// (R10) data bits, parity, stop bits and ascii or rtu are settable
// (R11) each port keeps and applies its own settings
module mbsp_top import mbsp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // module run state
  input wire logic run_i,
  // serial lines
  input wire logic [NPORT-1:0] rxd_i,
  output logic [NPORT-1:0] txd_o,
  // interrupt
  output logic irq_o
);

  // ----------------------------------------------------------
  // bus decode and millisecond tick
  // ----------------------------------------------------------
  logic [31:0] rd_word [NPORT];
  logic [NPORT-1:0] irq_p;
  logic [31:0] next_prdata;
  logic slverr, next_slverr, addr_ok, apb_wr, ms_tick;
  logic [19:0] ms_cnt, next_ms_cnt;

  assign addr_ok = (paddr_i[7:6] == 2'h0) && (paddr_i[1:0] == 2'h0);
  assign apb_wr = psel_i && penable_i && pwrite_i && addr_ok;
  assign pready_o = 1'b1;
  assign pslverr_o = slverr && psel_i && penable_i;
  assign irq_o = |irq_p;
  assign ms_tick = (ms_cnt == 20'(MS_CYC - 1));

  // read data and error caught in the setup cycle
  always_comb begin
    next_prdata = prdata_o;
    next_slverr = slverr;
    next_ms_cnt = ms_tick ? 20'h00000 : ms_cnt + 20'h00001;
    if (psel_i && !penable_i) begin
      next_slverr = !addr_ok;
      next_prdata = 32'h00000000;
      if (addr_ok && !pwrite_i) begin
        next_prdata = rd_word[paddr_i[PORT_BIT]];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
      slverr <= 1'b0;
      ms_cnt <= 20'h00000;
    end else begin
      prdata_o <= next_prdata;
      slverr <= next_slverr;
      ms_cnt <= next_ms_cnt;
    end
  end

  // hex digit of an ascii address character
  function automatic logic [3:0] hexv(input logic [7:0] c);
    hexv = (c[6]) ? 4'(c[3:0] + 4'h9) : c[3:0];
  endfunction

  // ----------------------------------------------------------
  // one set of settings and frame logic per port
  // ----------------------------------------------------------
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    mbsp_cfg_type cfg, next_cfg, wcfg;
    mbsp_rep_type rep, next_rep;
    logic [12:0] rate, next_rate, wrate, cur_rate;
    logic [11:0] dly, next_dly, tmo, next_tmo;
    logic [11:0] rcnt, next_rcnt, tcnt, next_tcnt;
    logic [NEV-1:0] stat, next_stat, mask, next_mask, ev;
    logic [7:0] txbuf, next_txbuf, rxbuf, next_rxbuf;
    logic [7:0] faddr, next_faddr, rxc;
    logic [20:0] acc, next_acc, sum;
    logic [9:0] gap, next_gap;
    logic [1:0] apos, next_apos;
    logic txpend, next_txpend, active, next_active;
    logic run_q, tick, next_tick, in_fr, next_in_fr;
    logic tmo_run, next_tmo_run, wr, rxv, rxe, rx_ok;
    logic fstart, fend, accept, tx_go, tx_rdy, tx_done;
    logic [4:0] ofs;

    assign ofs = paddr_i[4:0];
    assign wr = apb_wr && (paddr_i[PORT_BIT] == 1'(p));
    assign rx_ok = rxv && !rxe && active;
    assign tx_go = txpend && active && (cfg.master || rep == REP_OPEN);
    assign irq_p[p] = |(stat & mask);

    // character engine of this port
    mbsp_uart u_uart (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .fmt_i({cfg.stop2, cfg.par, cfg.data8}), // R10
      .tx_valid_i(tx_go),
      .tx_data_i(txbuf),
      .tx_ready_o(tx_rdy),
      .tx_done_o(tx_done),
      .txd_o(txd_o[p]),
      .rxd_i(rxd_i[p]),
      .rx_valid_o(rxv),
      .rx_err_o(rxe),
      .rx_data_o(rxc)
    );

    // register read view
    always_comb begin
      case (ofs)
        OFS_CFG: rd_word[p] = 32'(cfg);
        OFS_RATE: rd_word[p] = 32'(rate);
        OFS_DLY: rd_word[p] = 32'(dly);
        OFS_TMO: rd_word[p] = 32'(tmo);
        OFS_STAT: rd_word[p] = 32'(stat);
        OFS_MASK: rd_word[p] = 32'(mask);
        OFS_DATA: rd_word[p] = 32'(rxbuf);
        OFS_STATE: rd_word[p] = 32'({txpend, in_fr, rep, tmo_run,
          active});
        default: rd_word[p] = 32'h00000000;
      endcase
    end

    // settings written by software, range limited
    always_comb begin
      wcfg = mbsp_cfg_type'(pwdata_i[18:0]);
      if (wcfg.station < STATION_MIN || wcfg.station > STATION_MAX) begin
        wcfg.station = cfg.station; // R1
      end
      wrate = pwdata_i[12:0];
      if (wrate < RATE_MIN) begin
        wrate = RATE_MIN;
      end else if (wrate > RATE_MAX) begin
        wrate = RATE_MAX; // R7
      end
      cur_rate = cfg.custom ? rate : STD_RATE[cfg.baud]; // R7
      sum = acc + 21'({cur_rate, 4'h0});
    end

    // next values of settings, frame tracking and timers
    always_comb begin
      next_cfg = cfg;
      next_rate = rate;
      next_dly = dly;
      next_tmo = tmo;
      next_mask = mask;
      next_txbuf = txbuf;
      next_txpend = txpend;
      next_rxbuf = rxbuf;
      next_active = active;
      next_acc = sum;
      next_tick = 1'b0;
      next_in_fr = in_fr;
      next_apos = apos;
      next_faddr = faddr;
      next_gap = gap;
      next_rep = rep;
      next_rcnt = rcnt;
      next_tmo_run = tmo_run;
      next_tcnt = tcnt;
      ev = '0;
      // register writes, each port only its own window
      if (wr) begin // R11
        case (ofs)
          OFS_CFG: next_cfg = wcfg;
          OFS_RATE: next_rate = wrate;
          OFS_DLY: next_dly = (pwdata_i[11:0] > MS_MAX) ? MS_MAX
            : pwdata_i[11:0]; // R8
          OFS_TMO: next_tmo = (pwdata_i[11:0] > MS_MAX) ? MS_MAX
            : pwdata_i[11:0]; // R9
          OFS_MASK: next_mask = pwdata_i[NEV-1:0];
          OFS_DATA: begin
            if (!txpend) begin
              next_txbuf = pwdata_i[7:0];
              next_txpend = 1'b1;
            end
          end
          default: ;
        endcase
      end
      if (tx_go && tx_rdy) begin
        next_txpend = 1'b0;
      end
      // activation of the port
      if (cfg.pwr_on) begin
        next_active = 1'b1; // R6
      end else if (!run_i) begin
        next_active = 1'b0; // R5
      end else if (!run_q) begin
        next_active = 1'b1; // R5
      end
      // bit rate generator, 16 ticks per bit
      if (sum >= NCO_LIMIT) begin
        next_acc = sum - NCO_LIMIT; // R7
        next_tick = 1'b1;
      end
      // frame start and end, ascii or rtu
      fstart = rx_ok && (cfg.rtu ? !in_fr : rxc == CH_COLON);
      fend = cfg.rtu ? (in_fr && tick && !rx_ok
        && gap == RTU_GAP - 10'h001)
        : (rx_ok && in_fr && rxc == CH_LF); // R10
      accept = fend && (faddr == cfg.station
        || faddr == BCAST_ADDR); // R1 R3 R4
      if (tick && in_fr) begin
        next_gap = gap + 10'h001;
      end
      if (rx_ok) begin
        next_rxbuf = rxc;
        next_gap = 10'h000;
        if (in_fr && !cfg.rtu && apos != 2'h2) begin
          next_apos = apos + 2'h1;
          if (apos == 2'h0) begin
            next_faddr = {hexv(rxc), 4'h0};
          end else begin
            next_faddr = {faddr[7:4], hexv(rxc)};
          end
        end
      end
      if (fend) begin
        next_in_fr = 1'b0;
      end
      if (fstart) begin
        next_in_fr = 1'b1;
        next_apos = 2'h0;
        next_faddr = cfg.rtu ? rxc : faddr;
        next_rep = REP_IDLE;
      end
      // reply delay before a slave may answer
      case (rep)
        REP_IDLE: begin
          if (accept && faddr != BCAST_ADDR && !cfg.master) begin
            next_rep = REP_WAIT;
            next_rcnt = 12'h000;
          end
        end
        REP_WAIT: begin
          if (rcnt >= dly) begin
            next_rep = REP_OPEN; // R8
            ev[EV_REPLY] = 1'b1;
          end else if (ms_tick) begin
            next_rcnt = rcnt + 12'h001;
          end
        end
        REP_OPEN: ;
        default: next_rep = REP_IDLE;
      endcase
      // received data timeout after a master transmission
      if (tx_done && cfg.master && tmo != 12'h000) begin
        next_tmo_run = 1'b1;
        next_tcnt = 12'h000;
      end else if (rx_ok) begin
        next_tmo_run = 1'b0;
      end else if (tmo_run && ms_tick) begin
        next_tcnt = tcnt + 12'h001;
        if (tcnt == tmo - 12'h001) begin
          next_tmo_run = 1'b0; // R9
          ev[EV_TMO] = 1'b1;
        end
      end
      // events, a new event wins over a clear
      ev[EV_RXCHAR] = rx_ok;
      ev[EV_FRAME] = accept;
      ev[EV_BCAST] = accept && faddr == BCAST_ADDR; // R3
      ev[EV_ERR] = rxv && rxe && active;
      ev[EV_TXDONE] = tx_done;
      next_stat = stat;
      if (wr && ofs == OFS_STAT) begin
        next_stat = stat & ~pwdata_i[NEV-1:0];
      end
      next_stat = next_stat | ev;
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        cfg <= CFG_RST;
        rate <= RATE_RST;
        dly <= DLY_RST;
        tmo <= TMO_RST;
        stat <= '0;
        mask <= '0;
        txbuf <= 8'h00;
        txpend <= 1'b0;
        rxbuf <= 8'h00;
        active <= 1'b0;
        run_q <= 1'b0;
        acc <= 21'h000000;
        tick <= 1'b0;
        in_fr <= 1'b0;
        apos <= 2'h0;
        faddr <= 8'h00;
        gap <= 10'h000;
        rep <= REP_IDLE;
        rcnt <= 12'h000;
        tmo_run <= 1'b0;
        tcnt <= 12'h000;
      end else begin
        cfg <= next_cfg;
        rate <= next_rate;
        dly <= next_dly;
        tmo <= next_tmo;
        stat <= next_stat;
        mask <= next_mask;
        txbuf <= next_txbuf;
        txpend <= next_txpend;
        rxbuf <= next_rxbuf;
        active <= next_active;
        run_q <= run_i;
        acc <= next_acc;
        tick <= next_tick;
        in_fr <= next_in_fr;
        apos <= next_apos;
        faddr <= next_faddr;
        gap <= next_gap;
        rep <= next_rep;
        rcnt <= next_rcnt;
        tmo_run <= next_tmo_run;
        tcnt <= next_tcnt;
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/mbsp_top_sva.sv ----
// checker of the serial port block, top ports only
// assumes one clock domain and a bind onto mbsp_top
`timescale 1ns/1ps
`default_nettype none
module mbsp_top_sva import mbsp_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // serial lines and interrupt
  input wire logic [NPORT-1:0] txd_o,
  input wire logic irq_o
);
  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // ------------------------------------------
  // bus answers
  // ------------------------------------------
  AST_READY_CONST: assert property (pready_o)
    else $error("ready dropped");
  AST_ERR_ACCESS_ONLY: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access phase");
  AST_ERR_UNMAPPED: assert property (psel_i && penable_i &&
    (paddr_i[7:6] != 2'h0 || paddr_i[1:0] != 2'h0) |-> pslverr_o)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (psel_i && penable_i &&
    paddr_i[7:6] == 2'h0 && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped access refused");
  AST_WRITE_READS_ZERO: assert property (psel_i && !penable_i && pwrite_i
    |=> prdata_o == 32'h0)
    else $error("read data not zero on write");
  AST_PRDATA_HOLDS: assert property (!(psel_i && !penable_i)
    |=> $stable(prdata_o))
    else $error("read data moved outside setup");

  // ------------------------------------------
  // line and interrupt
  // ------------------------------------------
  AST_RESET_IDLE: assert property ($fell(rst_i) |->
    txd_o == '1 && !irq_o && prdata_o == 32'h0)
    else $error("outputs not idle after reset");
  AST_START_BIT0: assert property ($fell(txd_o[0]) |-> !txd_o[0] [*8])
    else $error("start bit too short on port 0");
  AST_START_BIT1: assert property ($fell(txd_o[1]) |-> !txd_o[1] [*8])
    else $error("start bit too short on port 1");

  // main scenarios
  cover property (pslverr_o);
  cover property ($rose(irq_o));
  cover property ($fell(txd_o[1]));
endmodule

bind mbsp_top mbsp_top_sva u_sva (.mclk_i(mclk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/mbsp_far_model.sv ----
// far side of one serial line: modbus master or slave
// assumes 7 data bits, even parity, 1 stop at a fixed bit time
`timescale 1ns/1ps
`default_nettype none
module mbsp_far_model #(
  parameter int BIT_CYC = 200
) (
  // clock
  input wire logic mclk_i,
  // line
  input wire logic txd_i,
  output logic rxd_o
);
  // idle line is high
  initial rxd_o = 1'b1;

  // one char, start low, lsb first, parity, stop
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, ^c[6:0], c[6:0], 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      rxd_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge mclk_i);
    end
  endtask

  // take one char: data in 6:0, parity in 7
  task automatic recv_char(output logic [7:0] c);
    int n;
    n = 0;
    c = '0;
    while (txd_i === 1'b1 && n < 20000) begin
      @(posedge mclk_i);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge mclk_i);
      c[i] = txd_i;
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/modbus_serial_port_config_tb.sv ----
// self-checking bench of the two serial ports
// assumes custom rate 5000 (bit of 200 cycles) and 20 cycles per ms
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value t=%0t got=%h exp=%h", \
  $time, g, e); end end
module modbus_serial_port_config_tb import mbsp_pkg::*;;
  logic mclk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic run, irq, err;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rxd, txd;
  int num_errors = 0;
  int comparisons = 0;

  mbsp_top #(.MS_CYC(20)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .run_i(run), .rxd_i(rxd),
    .txd_o(txd), .irq_o(irq));
  mbsp_far_model u_far0 (.mclk_i(mclk_i), .txd_i(txd[0]), .rxd_o(rxd[0]));
  mbsp_far_model u_far1 (.mclk_i(mclk_i), .txd_i(txd[1]), .rxd_o(rxd[1]));

  // ------------------------------------------
  // clock, bus and line helpers
  // ------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] ad(input int p, input logic [4:0] o);
    return 8'(p * 32) | {3'h0, o};
  endfunction

  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    // answer taken at the edge that sees ready high
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // read until a status bit shows, bounded
  task automatic poll(input int p, input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ad(p, OFS_STAT), 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
  endtask

  // ascii frame: colon, two address digits, line feed
  task automatic frame(input int p, input logic [7:0] h, input logic [7:0] l);
    logic [7:0] f [4];
    f = '{CH_COLON, h, l, CH_LF};
    foreach (f[i]) begin
      if (p == 1) u_far1.send_char(f[i]);
      else u_far0.send_char(f[i]);
    end
  endtask

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic t_regs;
    rchk(ad(0, OFS_CFG), 32'h08601);
    rchk(ad(0, OFS_RATE), 32'h60);
    rchk(ad(0, OFS_DLY), 32'h0);
    rchk(ad(0, OFS_TMO), 32'hc8);
    apb(1'b1, ad(0, OFS_RATE), 32'h1fff);
    rchk(ad(0, OFS_RATE), 32'h1388);
    apb(1'b1, ad(0, OFS_CFG), 32'h09000);
    rchk(ad(0, OFS_CFG), 32'h09001);
    apb(1'b1, ad(0, OFS_DLY), 32'hfff);
    rchk(ad(0, OFS_DLY), 32'hbb8);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, ad(1, OFS_RATE), 32'h1388);
  endtask

  task automatic t_stop_run;
    frame(0, 8'h30, 8'h31);
    rchk(ad(0, OFS_STAT), 32'h0);
    apb(1'b1, ad(1, OFS_CFG), 32'h09101);
    frame(1, 8'h30, 8'h31);
    poll(1, EV_FRAME);
    `CHK(rd[EV_FRAME], 1'b1)
    rchk(ad(0, OFS_STAT), 32'h0);
    run <= 1'b1;
    frame(0, 8'h30, 8'h31);
    poll(0, EV_FRAME);
    `CHK(rd[EV_FRAME], 1'b1)
    apb(1'b1, ad(0, OFS_STAT), 32'h7f);
  endtask

  task automatic t_bcast;
    apb(1'b1, ad(0, OFS_CFG), 32'h09011);
    frame(0, 8'h30, 8'h35);
    apb(1'b0, ad(0, OFS_STAT), 32'h0);
    `CHK(rd[EV_FRAME], 1'b0)
    frame(0, 8'h30, 8'h30);
    poll(0, EV_BCAST);
    `CHK(rd[EV_BCAST], 1'b1)
    `CHK(rd[EV_REPLY], 1'b0)
    apb(1'b1, ad(0, OFS_STAT), 32'h7f);
  endtask

  task automatic t_reply;
    apb(1'b1, ad(0, OFS_DLY), 32'h10);
    frame(0, 8'h31, 8'h31);
    poll(0, EV_FRAME);
    rchk(ad(0, OFS_STATE), 32'h5);
    poll(0, EV_REPLY);
    `CHK(rd[EV_REPLY], 1'b1)
    apb(1'b1, ad(0, OFS_DATA), 32'h41);
    u_far0.recv_char(c);
    `CHK(c, 8'h41)
  endtask

  task automatic t_master;
    apb(1'b1, ad(1, OFS_CFG), 32'h49101);
    apb(1'b1, ad(1, OFS_TMO), 32'h2);
    apb(1'b1, ad(1, OFS_MASK), 32'h20);
    apb(1'b1, ad(1, OFS_DATA), 32'h55);
    u_far1.recv_char(c);
    `CHK(c, 8'h55)
    poll(1, EV_TMO);
    `CHK(rd[EV_TMO], 1'b1)
    #1;
    `CHK(irq, 1'b1)
    apb(1'b1, ad(1, OFS_STAT), 32'h7f);
    #1;
    `CHK(irq, 1'b0)
  endtask

  // ------------------------------------------
  // sequence, watchdog and verdict
  // ------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    run = 1'b0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_regs;
    t_stop_run;
    t_bcast;
    t_reply;
    t_master;
    wrap_up;
  end

  initial begin
    repeat (90000) @(posedge mclk_i);
    num_errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
